// [hdl/hall_seq_pkg.sv]
// Shared constants, types and decode helpers for the hall power-mode sequencer
package hall_seq_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_HZ = 200_000_000;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam int WATCH_INTERVAL_MS = 80;
   localparam int TRACK_INTERVAL_MS = 20;
   localparam int WATCH_INTERVAL_CYC = WATCH_INTERVAL_MS * CYC_PER_MS;
   localparam int TRACK_INTERVAL_CYC = TRACK_INTERVAL_MS * CYC_PER_MS;
   localparam int TIMER_W = 24;

   ////////////////////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [7:0] ADDR_POWER_MODE = 8'h76;
   localparam logic [7:0] ADDR_X_RES = 8'h41;
   localparam logic [7:0] ADDR_Y_RES = 8'h52;
   localparam logic [7:0] ADDR_THR_POS_X = 8'h60;
   localparam logic [7:0] ADDR_THR_NEG_X = 8'h61;
   localparam logic [7:0] ADDR_THR_POS_Y = 8'h62;
   localparam logic [7:0] ADDR_THR_NEG_Y = 8'h63;
   localparam logic [7:0] ADDR_STATUS = 8'h20;

   // power_mode_control fields
   localparam int BIT_DUTY_CYCLED = 7;
   localparam int BIT_ACTIVE_SENSE = 6;
   localparam int BIT_CONTINUE = 5;
   localparam int BIT_WUP_EN = 4;
   localparam int BIT_COORD_EN = 3;
   localparam int BIT_SOFT_RST = 1;

   // Status fields
   localparam int ST_IRQ_BIT = 0;
   localparam int ST_PIN_BIT = 1;
   localparam int ST_MODE_LSB = 2;

   localparam logic [7:0] POWER_MODE_RESET = 8'h98;
   localparam logic [7:0] THR_POS_RESET = 8'h10;
   localparam logic [7:0] THR_NEG_RESET = 8'hf0;
   localparam logic [7:0] COORD_RESET = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {
      MODE_WATCH = 2'b00,
      MODE_TRACK = 2'b01,
      MODE_CONT = 2'b10
   } power_mode_t;

   typedef enum logic [1:0] {
      ST_SLEEP = 2'b00,
      ST_WAKE = 2'b01,
      ST_CONVERT = 2'b10
   } seq_state_t;

   typedef struct packed {
      logic write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_access_t;

   typedef struct packed {
      logic signed [7:0] x;
      logic signed [7:0] y;
   } coord_t;

   // Patterns with neither duty-cycled nor active-sense fall back to watch
   function automatic power_mode_t decode_mode(input logic [7:0] ctrl);
      if (ctrl[BIT_DUTY_CYCLED] && !ctrl[BIT_ACTIVE_SENSE]) begin
         return MODE_WATCH;
      end else if (ctrl[BIT_DUTY_CYCLED] && ctrl[BIT_ACTIVE_SENSE]) begin
         return MODE_TRACK;
      end else if (ctrl[BIT_ACTIVE_SENSE]) begin
         return MODE_CONT;
      end else begin
         return MODE_WATCH;
      end
   endfunction

endpackage

// [hdl/link_access_port.sv]
// Link-clock side of register access: holds one access and hands it to the core
`timescale 1ns/1ps
module link_access_port
   import hall_seq_pkg::*;
(
   input wire logic link_clk_in,         // Link clock, may stop between frames
   input wire logic rst_n_in,            // Core reset, synchronised here
   input wire logic acc_valid_in,        // Access offered
   input wire reg_access_t acc_in,       // Access word
   output logic acc_ready_out,           // Access taken when high with valid
   output logic [7:0] rd_data_out,       // Answer data of last access
   output logic done_out,                // One-cycle pulse: answer ready
   output logic req_tgl_out,             // Toggle per access, to core
   output reg_access_t req_word_out,     // Held access word, to core
   input wire logic ack_tgl_in,          // Toggle per answer, from core
   input wire logic [7:0] ack_data_in    // Answer data, from core
);

   logic rst_s1;
   logic link_rst_n;
   logic ack_s1;
   logic ack_s2;
   logic ack_prev;
   wire busy = req_tgl_out ^ ack_s2;
   wire take = acc_valid_in && acc_ready_out;
   wire answer = ack_s2 ^ ack_prev;

   assign acc_ready_out = !busy && link_rst_n;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset and answer toggle come from the core clock
   always_ff @(posedge link_clk_in) begin
      rst_s1 <= rst_n_in;
      link_rst_n <= rst_s1;
   end

   always_ff @(posedge link_clk_in) begin
      if (!link_rst_n) begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         ack_prev <= 1'b0;
      end else begin
         ack_s1 <= ack_tgl_in;
         ack_s2 <= ack_s1;
         ack_prev <= ack_s2;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Word stays still until the core answers, so it crosses safely
   always_ff @(posedge link_clk_in) begin
      if (!link_rst_n) begin
         req_tgl_out <= 1'b0;
         req_word_out <= '0;
      end else if (take) begin
         req_tgl_out <= ~req_tgl_out;
         req_word_out <= acc_in;
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (!link_rst_n) begin
         rd_data_out <= READ_UNMAPPED;
         done_out <= 1'b0;
      end else begin
         done_out <= answer;
         if (answer) begin
            rd_data_out <= ack_data_in;
         end
      end
   end

endmodule

// [hdl/hall_power_mode_sequencer.sv]
// Power-mode sequencer and motion interrupt for a four-element hall position sensor
//
// Contract
// - Reset enters threshold-watch mode, control pattern 1001_x00x.
// - Threshold-watch wakes every 80 ms, measures once, then sleeps.
// - Threshold-watch pulls interrupt low when position lies beyond any threshold.
// - Pattern 110x_100x selects tracking, waking every 20 ms with coordinate interrupt.
// - Tracking and continuous pull interrupt low on each new coordinate pair.
// - Pattern 010x_y00x selects continuous: full power, no sleep, back-to-back conversions.
// - Continuous with coordinate enable latches next sample after a read, holds it.
// - Continuous without coordinate enable returns latest conversion in real time.
// - Interrupt released by X or Y result read, or by a mode change.
// - Sleep stops the RC oscillator and analog section; logic keeps state.
// - Hall bias reduced in threshold-watch, high in tracking wakeups.
// - Four separately programmable thresholds: +X, -X, +Y, -Y.
// - Interrupt output is active low and open drain.
`timescale 1ns/1ps
module hall_power_mode_sequencer
   import hall_seq_pkg::*;
#(
   parameter int WATCH_CYC = WATCH_INTERVAL_CYC,
   parameter int TRACK_CYC = TRACK_INTERVAL_CYC
)(
   input wire logic clk_in,               // Core clock
   input wire logic rst_n_in,             // Synchronous reset, active low
   input wire logic link_clk_in,          // Link clock of the bus front end
   input wire logic acc_valid_in,         // Register access offered (link clock)
   input wire reg_access_t acc_in,        // Register access word (link clock)
   output logic acc_ready_out,            // Access accepted (link clock)
   output logic [7:0] rd_data_out,        // Answer data (link clock)
   output logic done_out,                 // Answer pulse (link clock)
   input wire logic conv_done_in,         // Front end finished a conversion
   input wire coord_t conv_coord_in,      // Converted coordinates
   output logic conv_start_out,           // Start one conversion
   output logic analog_pwr_on_out,        // Analog section powered
   output logic rc_osc_en_out,            // RC oscillator running
   output logic hall_bias_high_out,       // Hall elements at high bias
   input wire logic motion_irq_n_in,      // Interrupt line level
   output logic motion_irq_n_out,         // Interrupt drive value
   output logic motion_irq_oe_n_out       // Low while pulling the line
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0] power_mode_control;
   logic [7:0] thr_pos_x;
   logic [7:0] thr_neg_x;
   logic [7:0] thr_pos_y;
   logic [7:0] thr_neg_y;
   coord_t result;
   logic irq_pending;
   logic armed;
   seq_state_t state;
   seq_state_t next_state;
   logic [TIMER_W-1:0] timer;
   logic req_s1;
   logic req_s2;
   logic req_seen;
   logic ack_tgl;
   logic [7:0] ack_data;
   logic pin_s1;
   logic pin_level;
   logic link_req_tgl;
   reg_access_t link_word;
   logic sel_mode;
   logic sel_x_res;
   logic sel_y_res;
   logic sel_thr_pos_x;
   logic sel_thr_neg_x;
   logic sel_thr_pos_y;
   logic sel_thr_neg_y;
   logic sel_status;

   ////////////////////////////////////////////////////////////////////////////////
   // Link side
   link_access_port link_access_port_i (
      .link_clk_in(link_clk_in),
      .rst_n_in(rst_n_in),
      .acc_valid_in(acc_valid_in),
      .acc_in(acc_in),
      .acc_ready_out(acc_ready_out),
      .rd_data_out(rd_data_out),
      .done_out(done_out),
      .req_tgl_out(link_req_tgl),
      .req_word_out(link_word),
      .ack_tgl_in(ack_tgl),
      .ack_data_in(ack_data)
   );

   // Request toggle crosses from the link clock
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_seen <= 1'b0;
      end else begin
         req_s1 <= link_req_tgl;
         req_s2 <= req_s1;
         req_seen <= req_s2;
      end
   end

   // Line idles high through its pull-up, so reset matches that level
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pin_s1 <= 1'b1;
         pin_level <= 1'b1;
      end else begin
         pin_s1 <= motion_irq_n_in;
         pin_level <= pin_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Access decode
   wire req_edge = req_s2 ^ req_seen;
   wire wr = req_edge && link_word.write;
   wire rd = req_edge && !link_word.write;
   wire [7:0] waddr = link_word.addr;
   wire [7:0] wdata = link_word.wdata;

   // One select per register, shared by the write, read and clear paths
   assign sel_mode = (waddr == ADDR_POWER_MODE);
   assign sel_x_res = (waddr == ADDR_X_RES);
   assign sel_y_res = (waddr == ADDR_Y_RES);
   assign sel_thr_pos_x = (waddr == ADDR_THR_POS_X);
   assign sel_thr_neg_x = (waddr == ADDR_THR_NEG_X);
   assign sel_thr_pos_y = (waddr == ADDR_THR_POS_Y);
   assign sel_thr_neg_y = (waddr == ADDR_THR_NEG_Y);
   assign sel_status = (waddr == ADDR_STATUS);

   wire wr_mode = wr && sel_mode;
   wire soft_rst = wr_mode && wdata[BIT_SOFT_RST];
   wire [7:0] next_mode_ctrl = wdata & ~(8'h01 << BIT_SOFT_RST);

   power_mode_t mode;
   power_mode_t written_mode;
   assign mode = decode_mode(power_mode_control);
   assign written_mode = decode_mode(next_mode_ctrl);

   wire mode_change = wr_mode && ((written_mode != mode) || soft_rst);
   wire xy_read = rd && (sel_x_res || sel_y_res);
   wire wup_en = power_mode_control[BIT_WUP_EN];
   wire coord_en = power_mode_control[BIT_COORD_EN];

   wire [7:0] status_word = {4'h0, mode, pin_level, irq_pending};
   wire [7:0] rd_mux =
      sel_mode ? power_mode_control :
      sel_x_res ? result.x :
      sel_y_res ? result.y :
      sel_thr_pos_x ? thr_pos_x :
      sel_thr_neg_x ? thr_neg_x :
      sel_thr_pos_y ? thr_pos_y :
      sel_thr_neg_y ? thr_neg_y :
      sel_status ? status_word : READ_UNMAPPED;

   ////////////////////////////////////////////////////////////////////////////////
   // Register file
   // Soft-reset bit is stored cleared, so it always reads back as 0
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         power_mode_control <= POWER_MODE_RESET;
      end else if (wr_mode) begin
         power_mode_control <= next_mode_ctrl;
      end
   end

   // Thresholds return to defaults on a soft reset
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || soft_rst) begin
         thr_pos_x <= THR_POS_RESET;
      end else if (wr && sel_thr_pos_x) begin
         thr_pos_x <= wdata;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || soft_rst) begin
         thr_neg_x <= THR_NEG_RESET;
      end else if (wr && sel_thr_neg_x) begin
         thr_neg_x <= wdata;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || soft_rst) begin
         thr_pos_y <= THR_POS_RESET;
      end else if (wr && sel_thr_pos_y) begin
         thr_pos_y <= wdata;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || soft_rst) begin
         thr_neg_y <= THR_NEG_RESET;
      end else if (wr && sel_thr_neg_y) begin
         thr_neg_y <= wdata;
      end
   end

   // Every access is answered; writes answer with the unmapped value
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ack_tgl <= 1'b0;
         ack_data <= READ_UNMAPPED;
      end else if (req_edge) begin
         ack_tgl <= ~ack_tgl;
         ack_data <= link_word.write ? READ_UNMAPPED : rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interval timer
   // Counts on a clock that outlives the RC oscillator, so sleep does not stall it
   wire [TIMER_W-1:0] period_last = (mode == MODE_TRACK) ?
      TIMER_W'(TRACK_CYC - 1) : TIMER_W'(WATCH_CYC - 1);
   wire wake_tick = (timer == period_last);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || mode_change || wake_tick) begin
         timer <= '0;
      end else begin
         timer <= timer + TIMER_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Wake sequencer
   always_comb begin
      next_state = state;
      case (state)
         ST_SLEEP: begin
            if (mode == MODE_CONT || wake_tick) begin
               next_state = ST_WAKE;
            end
         end
         ST_WAKE: begin
            next_state = ST_CONVERT;
         end
         ST_CONVERT: begin
            if (conv_done_in) begin
               next_state = (mode == MODE_CONT) ? ST_WAKE : ST_SLEEP;
            end
         end
         default: begin
            next_state = ST_SLEEP;
         end
      endcase
   end

   // A mode change abandons the conversion in flight; its late result is dropped unless continuous mode has already reached ST_CONVERT again
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || mode_change) begin
         state <= ST_SLEEP;
      end else begin
         state <= next_state;
      end
   end

   // Power pins come from flops so the analog enables never glitch
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || mode_change) begin
         conv_start_out <= 1'b0;
         analog_pwr_on_out <= 1'b0;
         rc_osc_en_out <= 1'b0;
      end else begin
         conv_start_out <= (next_state == ST_WAKE);
         analog_pwr_on_out <= (next_state != ST_SLEEP);
         rc_osc_en_out <= (next_state != ST_SLEEP);
      end
   end

   // Follows the mode as it is written, so no wake sees the old bias
   wire next_bias = wr_mode ? (written_mode != MODE_WATCH) : (mode != MODE_WATCH);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         hall_bias_high_out <= 1'b0;
      end else begin
         hall_bias_high_out <= next_bias;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Results
   wire sample = (state == ST_CONVERT) && conv_done_in && !mode_change;
   wire signed [7:0] cx = conv_coord_in.x;
   wire signed [7:0] cy = conv_coord_in.y;
   // Strictly beyond: a position right on a threshold does not wake the host
   wire over_pos_x = (cx > $signed(thr_pos_x));
   wire over_neg_x = (cx < $signed(thr_neg_x));
   wire over_pos_y = (cy > $signed(thr_pos_y));
   wire over_neg_y = (cy < $signed(thr_neg_y));
   wire beyond = over_pos_x || over_neg_x || over_pos_y || over_neg_y;
   // Latching applies only in continuous mode with the coordinate interrupt on
   wire hold = (mode == MODE_CONT) && coord_en;
   wire load = sample && (!hold || armed);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || soft_rst) begin
         result <= {COORD_RESET, COORD_RESET};
      end else if (load) begin
         result <= conv_coord_in;
      end
   end

   // A read re-arms the latch; the sample loaded afterwards is held
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         armed <= 1'b1;
      end else if (xy_read || mode_change) begin
         armed <= 1'b1;
      end else if (load) begin
         armed <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Motion interrupt
   wire irq_set = sample && (
      (mode == MODE_WATCH) ? (beyond && wup_en) :
      (mode == MODE_TRACK) ? coord_en : 1'b1);
   wire irq_clear = xy_read || mode_change;

   // A new event in the clearing cycle wins, so no event is lost
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         irq_pending <= 1'b0;
      end else if (irq_set) begin
         irq_pending <= 1'b1;
      end else if (irq_clear) begin
         irq_pending <= 1'b0;
      end
   end

   // Open drain: only ever pulls low, never drives high
   assign motion_irq_n_out = 1'b0;
   assign motion_irq_oe_n_out = ~irq_pending;

endmodule

// [bench/hall_seq_properties.sv]
// Port-level checks for the hall power-mode sequencer
`timescale 1ns/1ps
module hall_seq_properties
   import hall_seq_pkg::*;
#(
   parameter int WATCH_CYC = 400,
   parameter int TRACK_CYC = 150
)(
   input wire logic clk_in, // core clock
   input wire logic rst_n_in, // reset
   input wire logic link_clk_in, // link clock
   input wire logic acc_valid_in, // access offered
   input wire logic acc_ready_out, // link port idle
   input wire logic done_out, // answer pulse
   input wire logic conv_start_out, // conversion start
   input wire logic rc_osc_en_out, // oscillator on
   input wire logic analog_pwr_on_out, // analog on
   input wire logic hall_bias_high_out, // high bias
   input wire logic motion_irq_n_out, // drive value
   input wire logic motion_irq_oe_n_out // drive enable
);
   int gap;
   // Saturates so the first wake after reset never looks early
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         gap <= 1000000;
      end else if (conv_start_out) begin
         gap <= 1;
      end else if (gap < 1000000) begin
         gap <= gap + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_drive_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      motion_irq_n_out == 1'b0) else $error("interrupt drive value not low");
   a_osc_analog: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      rc_osc_en_out == analog_pwr_on_out) else $error("oscillator and analog differ");
   a_start_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      conv_start_out |=> !conv_start_out) else $error("start longer than one cycle");
   a_start_awake: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      conv_start_out |-> rc_osc_en_out && analog_pwr_on_out) else $error("start while asleep");
   a_watch_spacing: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      conv_start_out && !hall_bias_high_out |-> gap >= WATCH_CYC) else $error("early watch wake");
   a_irq_after_conv: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $fell(motion_irq_oe_n_out) |-> $past(analog_pwr_on_out)) else $error("irq without sample");
   a_ready_busy: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
      acc_valid_in && acc_ready_out |=> !acc_ready_out) else $error("ready after take");
   a_answer_bound: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
      acc_valid_in && acc_ready_out |-> ##[2:10] done_out) else $error("answer missing");
   c_watch: cover property (@(posedge clk_in) conv_start_out && !hall_bias_high_out);
   c_irq: cover property (@(posedge clk_in) $fell(motion_irq_oe_n_out));
   c_done: cover property (@(posedge link_clk_in) done_out);
endmodule
bind hall_power_mode_sequencer hall_seq_properties #(
   .WATCH_CYC(WATCH_CYC), .TRACK_CYC(TRACK_CYC)) hall_seq_properties_i (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk_in),
   .acc_valid_in(acc_valid_in), .acc_ready_out(acc_ready_out), .done_out(done_out),
   .conv_start_out(conv_start_out), .rc_osc_en_out(rc_osc_en_out),
   .analog_pwr_on_out(analog_pwr_on_out), .hall_bias_high_out(hall_bias_high_out),
   .motion_irq_n_out(motion_irq_n_out), .motion_irq_oe_n_out(motion_irq_oe_n_out));

// [bench/hall_host_model.sv]
// Host model: gated link clock and single register accesses
`timescale 1ns/1ps
module hall_host_model
   import hall_seq_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h40
)(
   input wire logic rst_n_in, // link clock also runs in reset
   input wire logic acc_ready_in, // device idle
   input wire logic [7:0] rd_data_in, // answer data
   input wire logic done_in, // answer pulse
   output logic link_clk_out, // stands low between accesses
   output logic acc_valid_out, // access offered
   output reg_access_t acc_out // access word
);
   logic busy = 1'b0;
   initial begin
      link_clk_out = 1'b0;
      acc_valid_out = 1'b0;
      acc_out = '0;
      #7;
      forever begin
         #24;
         if (busy || !rst_n_in || link_clk_out) begin
            link_clk_out = ~link_clk_out;
         end
      end
   end
   // One access per frame, never chained
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      int n;
      n = 0;
      busy = 1'b1;
      do begin
         @(posedge link_clk_out);
         n++;
      end while (acc_ready_in !== 1'b1 && n < 20);
      acc_valid_out <= 1'b1;
      acc_out <= '{write: w, addr: a, wdata: d};
      @(posedge link_clk_out);
      acc_valid_out <= 1'b0;
      acc_out <= ~{w, a, d};
      do begin
         @(posedge link_clk_out);
         n++;
      end while (done_in !== 1'b1 && n < 40);
      // A missing answer reads as unknown, so the caller's compare fails
      q = (done_in === 1'b1) ? rd_data_in : 8'hxx;
      busy = 1'b0;
   endtask
   task automatic soft_reset();
      logic [7:0] q;
      xfer(1'b1, ADDR_POWER_MODE, 8'h9a, q);
      xfer(1'b1, ADDR_POWER_MODE, 8'h98, q);
   endtask
endmodule

// [bench/hall_power_mode_sequencer_tb.sv]
// Self-checking bench for the hall power-mode sequencer
`timescale 1ns/1ps
module hall_power_mode_sequencer_tb
   import hall_seq_pkg::*;
;
   localparam int WC = 400;
   localparam int TC = 150;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic link_clk, acc_valid, acc_ready, done, conv_start, analog, rc, bias, irq_o, irq_oe_n;
   logic conv_done = 1'b0;
   logic [1:0] sh = 2'b00;
   coord_t pos = '0;
   reg_access_t acc;
   logic [7:0] rd;
   wire logic irq_line = irq_oe_n ? 1'b1 : irq_o; // pull-up when released
   int num_errors = 0;
   int total_checks = 0;
   hall_power_mode_sequencer #(.WATCH_CYC(WC), .TRACK_CYC(TC)) hall_power_mode_sequencer_i (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk), .acc_valid_in(acc_valid),
      .acc_in(acc), .acc_ready_out(acc_ready), .rd_data_out(rd), .done_out(done),
      .conv_done_in(conv_done), .conv_coord_in(pos), .conv_start_out(conv_start),
      .analog_pwr_on_out(analog), .rc_osc_en_out(rc), .hall_bias_high_out(bias),
      .motion_irq_n_in(irq_line), .motion_irq_n_out(irq_o), .motion_irq_oe_n_out(irq_oe_n));
   hall_host_model hall_host_model_i (.rst_n_in(rst_n_in), .acc_ready_in(acc_ready),
      .rd_data_in(rd), .done_in(done), .link_clk_out(link_clk), .acc_valid_out(acc_valid),
      .acc_out(acc));
   initial forever #2.5 clk_in = ~clk_in;
   // Front end answers three cycles after each start
   always @(posedge clk_in) begin
      sh <= {sh[0], conv_start};
      conv_done <= sh[1];
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic chkn(input int got, input int exp);
      total_checks++;
      if (got != exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      hall_host_model_i.xfer(1'b0, a, 8'h00, q);
      chk8(q, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      hall_host_model_i.xfer(1'b1, a, d, q);
      chk8(q, READ_UNMAPPED);
   endtask
   task automatic wait_start(output int n);
      n = 0;
      do begin @(posedge clk_in); n++; end while (conv_start !== 1'b1 && n < 1000);
      if (conv_start !== 1'b1) begin
         num_errors++;
      end
   endtask
   task automatic settle(input coord_t p);
      @(posedge clk_in);
      pos <= p;
      repeat (20) @(posedge clk_in);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd_chk(ADDR_POWER_MODE, 8'h98);
      hall_host_model_i.soft_reset();
      rd_chk(ADDR_THR_POS_X, 8'h10);
      rd_chk(ADDR_THR_NEG_X, 8'hf0);
      rd_chk(ADDR_THR_POS_Y, 8'h10);
      rd_chk(ADDR_THR_NEG_Y, 8'hf0);
      wr(8'h7f, 8'h5a);
      rd_chk(8'h7f, READ_UNMAPPED);
      chk1(irq_line, 1'b1);
      $display("reset test done");
   endtask
   task automatic t_watch();
      int n;
      wait_start(n);
      chk1(bias, 1'b0);
      wait_start(n);
      chkn(n, WC);
      repeat (8) @(posedge clk_in);
      chk1(rc, 1'b0);
      chk1(irq_line, 1'b1);
      wr(ADDR_THR_POS_Y, 8'h05);
      settle('{x: 8'sh00, y: 8'sh08});
      wait_start(n);
      repeat (8) @(posedge clk_in);
      chk1(irq_line, 1'b0);
      rd_chk(ADDR_STATUS, 8'h01);
      rd_chk(ADDR_X_RES, 8'h00);
      chk1(irq_line, 1'b1);
      $display("watch test done");
   endtask
   task automatic t_track();
      int n;
      wait_start(n);
      repeat (8) @(posedge clk_in);
      wr(ADDR_POWER_MODE, 8'hc8);
      chk1(irq_line, 1'b1);
      wait_start(n);
      chk1(bias, 1'b1);
      wait_start(n);
      chkn(n, TC);
      repeat (8) @(posedge clk_in);
      chk1(irq_line, 1'b0);
      rd_chk(ADDR_Y_RES, 8'h08);
      chk1(irq_line, 1'b1);
      rd_chk(ADDR_STATUS, 8'h06);
      $display("track test done");
   endtask
   task automatic t_cont();
      int n;
      wr(ADDR_POWER_MODE, 8'h48);
      wait_start(n);
      wait_start(n);
      chkn(n < 10, 1);
      settle('{x: 8'sh11, y: 8'sh22});
      chk1(irq_line, 1'b0);
      rd_chk(ADDR_X_RES, 8'h00);
      settle('{x: 8'sh33, y: 8'sh44});
      rd_chk(ADDR_Y_RES, 8'h22);
      wr(ADDR_POWER_MODE, 8'h40);
      settle('{x: 8'sh55, y: 8'sh66});
      rd_chk(ADDR_X_RES, 8'h55);
      settle('{x: 8'sh77, y: 8'sh66});
      rd_chk(ADDR_X_RES, 8'h77);
      $display("continuous test done");
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Reset spans enough link edges for the link side to see it
   initial begin
      repeat (40) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_reset();
      t_watch();
      t_track();
      t_cont();
      close_out();
   end
   initial begin
      #200000;
      num_errors++;
      close_out();
   end
endmodule
